// file: hw/ssw_map.svh
// constants of the supply supervisor and wake mask block
`ifndef SSW_MAP_SVH
`define SSW_MAP_SVH

// ****************************************
// timing
// ****************************************
`define SSW_CLK_MHZ        250
`define SSW_T_FP_NS        2000
`define SSW_T_NORM_NS      150000
`define SSW_T_WAKE_FAST_NS 2000
`define SSW_T_WAKE_SLOW_NS 150000
`define SSW_CNT_W          16

// ****************************************
// register offsets
// ****************************************
`define SSW_OFF_CTRL       8'h00
`define SSW_OFF_DIV        8'h04
`define SSW_OFF_FLAGS      8'h08
`define SSW_OFF_INT_STAT   8'h0c
`define SSW_OFF_INT_CLR    8'h10
`define SSW_OFF_INT_EN     8'h14

// ****************************************
// control fields
// ****************************************
`define SSW_B_LSUP_ON      0
`define SSW_B_LMON_ON      1
`define SSW_B_LSUP_FP      2
`define SSW_B_LMON_FP      3
`define SSW_B_LKEEP        4
`define SSW_B_LRST_EN      5
`define SSW_B_HSUP_ON      8
`define SSW_B_HSUP_FP      10
`define SSW_B_HKEEP        12
`define SSW_B_HRST_EN      13
`define SSW_CTRL_RST       32'h0000_2123
`define SSW_CTRL_MASK      32'h0000_353f

// ****************************************
// flags, status and interrupt bits
// ****************************************
`define SSW_B_FLAG_L       0
`define SSW_B_FLAG_H       1
`define SSW_B_ST_BUSY_L    8
`define SSW_B_ST_BUSY_H    9
`define SSW_B_ST_STALL     10
`define SSW_B_ST_HIZ       11
`define SSW_INT_W          5
`define SSW_DIV_W          3
`define SSW_DIV_RST        3'h0
`define SSW_INT_RST        5'h00

`endif

// file: hw/ssw_pkg.sv
// types of the supply supervisor and wake mask block
package ssw_pkg;

    typedef enum logic {
        SSW_T_IDLE,
        SSW_T_RUN
    } ssw_tmr_st_t;

    typedef struct packed {
        logic h_rst_en;
        logic h_keep;
        logic h_fp;
        logic h_on;
        logic l_rst_en;
        logic l_keep;
        logic l_mon_fp;
        logic l_sup_fp;
        logic l_mon_on;
        logic l_sup_on;
    } ssw_ctrl_t;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
    } ssw_ahb_ph_t;

    typedef struct packed {
        ssw_ctrl_t   ctrl;
        logic [2:0]  div;
        logic [1:0]  flags;
        logic [4:0]  int_stat;
        logic [4:0]  int_en;
        ssw_ahb_ph_t ph;
        logic [31:0] rdata;
        logic [2:0]  lpm_prev;
        logic        l_en;
        logic        h_en;
        logic        boot;
        logic        por;
    } ssw_state_t;

    typedef struct packed {
        ssw_tmr_st_t st;
        logic [15:0] cnt;
        logic        done;
    } ssw_tmr_t;

endpackage : ssw_pkg

// file: hw/ssw_timer.sv
// one-shot settling timer with restart
`timescale 1ns/10ps
`include "ssw_map.svh"

module ssw_timer
    import ssw_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        start_i,
    input  wire logic [15:0] load_i,
    output logic             busy_o,
    output logic             done_o
);

    ssw_tmr_t s_q;
    ssw_tmr_t s_d;

    // ****************************************
    // count down, a start restarts at once
    // ****************************************
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (start_i) begin
            s_d.st  = SSW_T_RUN;
            s_d.cnt = load_i;
        end else begin
            unique case (s_q.st)
                SSW_T_IDLE: begin
                end
                SSW_T_RUN: begin
                    if (s_q.cnt <= 16'h0001) begin
                        s_d.st   = SSW_T_IDLE;
                        s_d.cnt  = 16'h0000;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{st: SSW_T_IDLE, cnt: 16'h0000, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = (s_q.st == SSW_T_RUN);
    assign done_o = s_q.done;

endmodule : ssw_timer

// file: hw/ssw_supervisor.sv
// supply supervisor control with event masking, pin float and wake stall
//
// Functional notes
// - mask events 2 us after full-performance re-enable
// - keep-on 0: comparators off in sleep 2-4
// - trip sets flag, optional power-on reset
// - flags set: pins float until settled
// - reset or soft clear turns supervisors on
// - normal low side: stall wake 150 us
// - low side off or full: stall 2 us
`timescale 1ns/10ps
`include "ssw_map.svh"

module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter int NORM_CYC = (`SSW_T_NORM_NS * `SSW_CLK_MHZ) / 1000,
    parameter int WAKE_SLOW_CYC = (`SSW_T_WAKE_SLOW_NS * `SSW_CLK_MHZ) / 1000
) (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [2:0]  lpm_mode_i,
    input  wire logic        soft_power_up_clear_i,
    input  wire logic        low_trip_i,
    input  wire logic        high_trip_i,
    output logic             low_comparator_en_o,
    output logic             high_comparator_en_o,
    output logic             por_req_o,
    output logic             gpio_hiz_o,
    output logic             cpu_stall_o,
    output logic [2:0]       main_clock_divider_o,
    output logic             irq_o
);

    localparam int          FP_CYC_I     = (`SSW_T_FP_NS * `SSW_CLK_MHZ) / 1000;
    localparam int          WFAST_CYC_I  = (`SSW_T_WAKE_FAST_NS * `SSW_CLK_MHZ) / 1000;
    localparam logic [15:0] FP_CYC       = 16'(FP_CYC_I);
    localparam logic [15:0] NORM_CYC_W   = 16'(NORM_CYC);
    localparam logic [15:0] WFAST_CYC    = 16'(WFAST_CYC_I);
    localparam logic [15:0] WSLOW_CYC    = 16'(WAKE_SLOW_CYC);
    localparam int          NCH          = 3;

    ssw_state_t  s_q;
    ssw_state_t  s_d;
    logic [2:0]  t_start;
    logic [15:0] t_load [NCH];
    logic [2:0]  t_busy;
    logic [2:0]  t_done;

    // ****************************************
    // settling and wake timers
    // ****************************************
    generate
        for (genvar i = 0; i < NCH; i++) begin : g_tmr
            ssw_timer u_tmr (
                .clk_sys_i (clk_sys_i),
                .nrst_i    (nrst_i),
                .start_i   (t_start[i]),
                .load_i    (t_load[i]),
                .busy_o    (t_busy[i]),
                .done_o    (t_done[i])
            );
        end
    endgenerate

    function automatic ssw_ctrl_t ctrl_unpack(input logic [31:0] w);
        ssw_ctrl_t c;
        c.l_sup_on = w[`SSW_B_LSUP_ON];
        c.l_mon_on = w[`SSW_B_LMON_ON];
        c.l_sup_fp = w[`SSW_B_LSUP_FP];
        c.l_mon_fp = w[`SSW_B_LMON_FP];
        c.l_keep   = w[`SSW_B_LKEEP];
        c.l_rst_en = w[`SSW_B_LRST_EN];
        c.h_on     = w[`SSW_B_HSUP_ON];
        c.h_fp     = w[`SSW_B_HSUP_FP];
        c.h_keep   = w[`SSW_B_HKEEP];
        c.h_rst_en = w[`SSW_B_HRST_EN];
        return c;
    endfunction : ctrl_unpack

    function automatic logic [31:0] ctrl_pack(input ssw_ctrl_t c);
        logic [31:0] w;
        w                 = 32'h0000_0000;
        w[`SSW_B_LSUP_ON] = c.l_sup_on;
        w[`SSW_B_LMON_ON] = c.l_mon_on;
        w[`SSW_B_LSUP_FP] = c.l_sup_fp;
        w[`SSW_B_LMON_FP] = c.l_mon_fp;
        w[`SSW_B_LKEEP]   = c.l_keep;
        w[`SSW_B_LRST_EN] = c.l_rst_en;
        w[`SSW_B_HSUP_ON] = c.h_on;
        w[`SSW_B_HSUP_FP] = c.h_fp;
        w[`SSW_B_HKEEP]   = c.h_keep;
        w[`SSW_B_HRST_EN] = c.h_rst_en;
        return w;
    endfunction : ctrl_pack

    logic       deep_now;
    logic       l_en;
    logic       h_en;
    logic       acc_l;
    logic       acc_h;
    logic       wake34;
    logic       wake_fast;
    logic       addr_ph;
    logic       wr_ph;
    logic [4:0] ev;
    logic [4:0] clr;
    logic [1:0] flag_clr;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d       = s_q;
        s_d.boot  = 1'b0;
        clr       = 5'h00;
        flag_clr  = 2'b00;

        deep_now  = (lpm_mode_i >= 3'h2) && (lpm_mode_i <= 3'h4);
        l_en      = s_q.ctrl.l_sup_on && (!deep_now || s_q.ctrl.l_keep);
        h_en      = s_q.ctrl.h_on && (!deep_now || s_q.ctrl.h_keep);

        // trips count only while the comparator is on and settled
        acc_l     = low_trip_i && s_q.l_en && !t_busy[0];
        acc_h     = high_trip_i && s_q.h_en && !t_busy[1];

        // restart settling on switch-on, after a trip and after any reset
        t_start[0] = (l_en && !s_q.l_en) || acc_l || s_q.boot || soft_power_up_clear_i;
        t_start[1] = (h_en && !s_q.h_en) || acc_h || s_q.boot || soft_power_up_clear_i;
        t_load[0]  = s_q.ctrl.l_sup_fp ? FP_CYC : NORM_CYC_W;
        t_load[1]  = s_q.ctrl.h_fp ? FP_CYC : NORM_CYC_W;

        wake34     = ((s_q.lpm_prev == 3'h3) || (s_q.lpm_prev == 3'h4)) && (lpm_mode_i == 3'h0);
        wake_fast  = (!s_q.ctrl.l_sup_on && !s_q.ctrl.l_mon_on)
                   || (s_q.ctrl.l_sup_fp && s_q.ctrl.l_mon_fp);
        t_start[2] = wake34;
        t_load[2]  = wake_fast ? WFAST_CYC : WSLOW_CYC;

        s_d.l_en     = l_en;
        s_d.h_en     = h_en;
        s_d.lpm_prev = lpm_mode_i;
        s_d.por      = (acc_l && s_q.ctrl.l_rst_en) || (acc_h && s_q.ctrl.h_rst_en);

        // bus address phase is taken, write data arrive one cycle later
        addr_ph     = hsel_i && htrans_i[1] && hready_i;
        wr_ph       = s_q.ph.sel && s_q.ph.write;
        s_d.ph.sel  = addr_ph;
        s_d.ph.write = hwrite_i;
        s_d.ph.addr = haddr_i[7:0];
        if (addr_ph && !hwrite_i) begin
            unique case (haddr_i[7:0])
                `SSW_OFF_CTRL:     s_d.rdata = ctrl_pack(s_q.ctrl);
                `SSW_OFF_DIV:      s_d.rdata = {29'h0, s_q.div};
                `SSW_OFF_FLAGS:    s_d.rdata = {20'h0, gpio_hiz_o, t_busy[2], t_busy[1], t_busy[0],
                                                6'h00, s_q.flags};
                `SSW_OFF_INT_STAT: s_d.rdata = {27'h0, s_q.int_stat};
                `SSW_OFF_INT_EN:   s_d.rdata = {27'h0, s_q.int_en};
                default:           s_d.rdata = 32'h0000_0000;
            endcase
        end

        if (wr_ph) begin
            unique case (s_q.ph.addr)
                `SSW_OFF_CTRL:     s_d.ctrl = ctrl_unpack(hwdata_i);
                `SSW_OFF_DIV:      s_d.div = hwdata_i[2:0];
                `SSW_OFF_FLAGS:    flag_clr = hwdata_i[1:0];
                `SSW_OFF_INT_CLR:  clr = hwdata_i[4:0];
                `SSW_OFF_INT_EN:   s_d.int_en = hwdata_i[4:0];
                default: begin
                end
            endcase
        end

        // soft clear puts control back to defaults with both sides on
        if (soft_power_up_clear_i) begin
            s_d.ctrl = ctrl_unpack(`SSW_CTRL_RST);
        end

        // set wins over clear
        s_d.flags = (s_q.flags & ~flag_clr) | {acc_h, acc_l};
        ev        = {t_done[2], t_done[1], t_done[0], acc_h, acc_l};
        s_d.int_stat = (s_q.int_stat & ~clr) | ev;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q.ctrl     <= ctrl_unpack(`SSW_CTRL_RST);
            s_q.div      <= `SSW_DIV_RST;
            s_q.flags    <= 2'b00;
            s_q.int_stat <= `SSW_INT_RST;
            s_q.int_en   <= `SSW_INT_RST;
            s_q.ph       <= '{sel: 1'b0, write: 1'b0, addr: 8'h00};
            s_q.rdata    <= 32'h0000_0000;
            s_q.lpm_prev <= 3'h0;
            s_q.l_en     <= 1'b0;
            s_q.h_en     <= 1'b0;
            s_q.boot     <= 1'b1;
            s_q.por      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hrdata_o             = s_q.rdata;
    assign hreadyout_o          = 1'b1;
    assign hresp_o              = 1'b0;
    assign low_comparator_en_o  = s_q.l_en;
    assign high_comparator_en_o = s_q.h_en;
    assign por_req_o            = s_q.por;
    assign gpio_hiz_o           = (s_q.flags[0] && t_busy[0]) || (s_q.flags[1] && t_busy[1]);
    assign cpu_stall_o          = t_busy[2];
    assign main_clock_divider_o = s_q.div;
    assign irq_o                = |(s_q.int_stat & s_q.int_en);

endmodule : ssw_supervisor

// file: bench/ssw_supervisor_props.sv
// assertion checker of the supply supervisor block
`timescale 1ns/10ps

module ssw_supervisor_props #(
    parameter int NORM_CYC      = 40,
    parameter int WAKE_SLOW_CYC = 60
) (
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [2:0]  lpm_mode_i,
    input wire logic        soft_power_up_clear_i,
    input wire logic        low_trip_i,
    input wire logic        high_trip_i,
    input wire logic        low_comparator_en_o,
    input wire logic        high_comparator_en_o,
    input wire logic        por_req_o,
    input wire logic        gpio_hiz_o,
    input wire logic        cpu_stall_o
);
    // ****************************************
    // control mirror and counters
    // ****************************************
    logic [15:0] ctrl_q;
    logic        wr_q;
    logic [2:0]  lpm_q;
    logic [15:0] boot_q;
    logic [15:0] stall_q;
    logic [15:0] slen_q;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q  <= 16'h2123;
            wr_q    <= 1'b0;
            lpm_q   <= 3'h0;
            boot_q  <= 16'h0000;
            stall_q <= 16'h0000;
            slen_q  <= 16'h0000;
        end else begin
            wr_q    <= hsel_i & htrans_i[1] & hready_i & hwrite_i & (haddr_i[7:0] == 8'h00);
            lpm_q   <= lpm_mode_i;
            boot_q  <= soft_power_up_clear_i ? 16'h0000 : boot_q + {15'h0000, boot_q != 16'hffff};
            stall_q <= cpu_stall_o ? stall_q + 16'h0001 : 16'h0000;
            if (soft_power_up_clear_i)
                ctrl_q <= 16'h2123;
            else if (wr_q)
                ctrl_q <= hwdata_i[15:0] & 16'h353f;
            if (lpm_mode_i == 3'h0 && lpm_q inside {3'h3, 3'h4})
                slen_q <= (ctrl_q[1:0] == 2'h0 || ctrl_q[3:2] == 2'h3) ? 16'h01f4 : WAKE_SLOW_CYC[15:0];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus answer not ready and okay");
    low_en_a: assert property ($past(nrst_i) |-> low_comparator_en_o ==
        $past(ctrl_q[0] & (lpm_mode_i < 3'h2 | lpm_mode_i > 3'h4 | ctrl_q[4])))
        else $error("low comparator enable wrong");
    high_en_a: assert property ($past(nrst_i) |-> high_comparator_en_o ==
        $past(ctrl_q[8] & (lpm_mode_i < 3'h2 | lpm_mode_i > 3'h4 | ctrl_q[12])))
        else $error("high comparator enable wrong");
    stall_start_a: assert property ($rose(cpu_stall_o) |-> $past(lpm_mode_i) == 3'h0 &&
        ($past(lpm_mode_i, 2) inside {3'h3, 3'h4} || $past(lpm_mode_i, 3) inside {3'h3, 3'h4}))
        else $error("stall without wake");
    stall_len_a: assert property ($fell(cpu_stall_o) |-> stall_q == slen_q)
        else $error("stall length wrong");
    por_cause_a: assert property (por_req_o |-> ($past(low_trip_i) && $past(ctrl_q[5])) ||
        ($past(high_trip_i) && $past(ctrl_q[13])))
        else $error("reset request without enabled trip");
    por_once_a: assert property (por_req_o |=> !por_req_o [*8]) else $error("trip not masked");
    por_hiz_a: assert property (por_req_o |-> gpio_hiz_o [*8]) else $error("pins not floating");
    boot_mask_a: assert property (por_req_o |-> boot_q >= NORM_CYC) else $error("trip during boot settling");
endmodule : ssw_supervisor_props

bind ssw_supervisor ssw_supervisor_props #(.NORM_CYC(NORM_CYC), .WAKE_SLOW_CYC(WAKE_SLOW_CYC)) ssw_supervisor_props_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .lpm_mode_i(lpm_mode_i), .soft_power_up_clear_i(soft_power_up_clear_i), .low_trip_i(low_trip_i),
    .high_trip_i(high_trip_i), .low_comparator_en_o(low_comparator_en_o), .high_comparator_en_o(high_comparator_en_o),
    .por_req_o(por_req_o), .gpio_hiz_o(gpio_hiz_o), .cpu_stall_o(cpu_stall_o));

// file: bench/tb.sv
// self-checking testbench of the supply supervisor block
`timescale 1ns/10ps
`include "ssw_map.svh"

module tb;
    logic        clk_sys, nrst, hsel, hwrite, low_trip, high_trip, soft_clr;
    logic        hready, hresp, low_en, high_en, por, hiz, stall, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, k;
    logic [2:0]  lpm, m, div;
    localparam int NORM_C  = 40;
    localparam int WSLOW_C = 60;
    logic [31:0] cfg[4] = '{32'h2123, 32'h2120, 32'h213f, 32'h2137};
    int          err_count, checks_done, por_seen, i, n;

    ssw_supervisor #(.NORM_CYC(NORM_C), .WAKE_SLOW_CYC(WSLOW_C)) ssw_supervisor_inst (
        .clk_sys_i(clk_sys), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .lpm_mode_i(lpm), .soft_power_up_clear_i(soft_clr), .low_trip_i(low_trip),
        .high_trip_i(high_trip), .low_comparator_en_o(low_en), .high_comparator_en_o(high_en), .por_req_o(por),
        .gpio_hiz_o(hiz), .cpu_stall_o(stall), .main_clock_divider_o(div), .irq_o(irq));

    // ****************************************
    // clock, watchdog and tasks
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) if (por === 1'b1) por_seen++;

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        stop_test();
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : cyc

    // comparator enables that a control word asks for in a given power mode
    function automatic logic [1:0] exp_en(input logic [31:0] c, input logic [2:0] md);
        logic deep;
        deep = (md >= 3'h2) && (md <= 3'h4);
        return {c[`SSW_B_LSUP_ON] & (!deep | c[`SSW_B_LKEEP]),
                c[`SSW_B_HSUP_ON] & (!deep | c[`SSW_B_HKEEP])};
    endfunction : exp_en

    // wake stall: short when the low side is all off or all full performance
    function automatic int exp_stall(input logic [31:0] c);
        if ((!c[`SSW_B_LSUP_ON] && !c[`SSW_B_LMON_ON]) || (c[`SSW_B_LSUP_FP] && c[`SSW_B_LMON_FP]))
            return (`SSW_T_WAKE_FAST_NS * `SSW_CLK_MHZ) / 1000;
        return WSLOW_C;
    endfunction : exp_stall

    // cycles for which the stall or the pin float output stands once it rises
    task automatic count_high(input bit pick_hiz, output int c);
        c = 0;
        for (int t = 0; t < 2000; t++) begin
            @(posedge clk_sys);
            if ((pick_hiz ? hiz : stall) === 1'b1) c++;
            else if (c > 0) break;
        end
    endtask : count_high

    // one single AHB transfer, read data left in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h000000, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // ****************************************
    // tests
    // ****************************************
    initial begin
        {nrst, hsel, hwrite, high_trip, soft_clr, haddr, hwdata, htrans, lpm} <= '0;
        low_trip <= 1'b1;
        void'($urandom(73446));
        cyc(12);
        nrst <= 1'b1;
        ahb(0, 8'h00, 0); chk(rd, 32'h2123);
        ahb(0, 8'h04, 0); chk(rd, 0);
        ahb(0, 8'h14, 0); chk(rd, 0);
        for (i = 0; i < 200 && por !== 1'b1; i++) @(posedge clk_sys);
        chk(32'({por, hiz}), 3);
        low_trip <= 1'b0;
        cyc(45); chk(32'(hiz), 0);
        ahb(0, 8'h08, 0); chk(rd & 32'h3, 1);
        chk(32'(irq), 0);
        ahb(1, 8'h14, 1); cyc(2); chk(32'(irq), 1);
        ahb(1, 8'h10, 1); cyc(2); chk(32'(irq), 0);
        ahb(1, 8'h08, 1); ahb(0, 8'h08, 0); chk(rd & 32'h3, 0);
        ahb(1, 8'h00, 32'h0123);
        n = por_seen;
        high_trip <= 1'b1; cyc(3);
        high_trip <= 1'b0; cyc(3);
        chk(por_seen, n);
        ahb(0, 8'h08, 0); chk(rd & 32'h3, 2);
        ahb(1, 8'h04, 1); ahb(0, 8'h04, 0); chk(rd, 1); chk(32'(div), 1);
        ahb(1, 8'h40, 32'hffffffff); ahb(0, 8'h40, 0); chk(rd, 0);
        for (i = 0; i < 8; i++) begin
            k = 2'($urandom);
            m = 3'($urandom % 3);
            ahb(1, 8'h00, 32'h2123 | {19'h0, k[1], 7'h00, k[0], 4'h0});
            lpm <= m;
            cyc(3);
            chk(32'({low_en, high_en}), 32'(exp_en(32'h2123 | {19'h0, k[1], 7'h00, k[0], 4'h0}, m)));
        end
        lpm <= 3'h0;
        for (i = 0; i < 4; i++) begin
            ahb(1, 8'h00, cfg[i] & 32'hffff_fff3); cyc(NORM_C + 5);
            ahb(1, 8'h00, cfg[i]);
            m = 3'h3 + 3'($urandom % 2);
            lpm <= m;
            cyc(4); chk(32'({low_en, high_en}), 32'(exp_en(cfg[i], m)));
            lpm <= 3'h0;
            count_high(1'b0, n);
            chk(n, exp_stall(cfg[i]));
            if (i == 2) begin
                low_trip <= 1'b1; cyc(1);
                low_trip <= 1'b0;
                count_high(1'b1, n);
                chk(n, (`SSW_T_FP_NS * `SSW_CLK_MHZ) / 1000);
            end
        end
        cyc(100); ahb(1, 8'h04, 0); cyc(1); chk(32'(div), 0);
        ahb(1, 8'h00, 0); cyc(2); chk(32'({low_en, high_en}), 0);
        soft_clr <= 1'b1; cyc(1);
        soft_clr <= 1'b0; cyc(2); chk(32'({low_en, high_en}), 3);
        ahb(0, 8'h00, 0); chk(rd, 32'h2123);
        stop_test();
    end
endmodule : tb
